// *** rtl/i2c_master_bus_collision_brg.v ***
// i2c master start, repeated start, stop with collision checks
// Operation
// - start: either line low at begin collides
// - start: scl low before sda asserted collides
// - start collision: abort, flag, go idle
// - start: sda high loads counter, counts down
// - start: sda low mid-count, reset, assert early
// - start: sda low at end, count, scl low
// - repeated start: sda low at scl rise collides
// - repeated start: count, release scl, sample sda
// - repeated start: reload; foreign sda fall is fine
// - repeated start: early scl fall collides
// - repeated start: drive sda, count, drive scl
// - stop: sda low after timeout collides
// - stop: scl low before sda high collides
// - stop: sda low, release scl, count, sample
// - one counter clocks i2c and spi masters
// - buffer write starts counter automatically
// - counter stops at end, clock holds level
// - two reloads per serial clock period
// - abort releases lines, clears sequence enables
`timescale 1ns/1ps
`default_nettype none
`include "i2c_collision_regs.vh"

module i2c_master_bus_collision_brg #(
  parameter RELOAD_W = 8,
  parameter DATA_W   = 8
) (
  input  wire                clock_i,
  input  wire                rst_n_i,
  input  wire                port_enable_i,
  input  wire [3:0]          port_mode_select_i,
  input  wire [RELOAD_W-1:0] rate_reload_value_i,
  input  wire                start_req_i,
  input  wire                rstart_req_i,
  input  wire                stop_req_i,
  input  wire                transfer_buffer_wr_i,
  input  wire [DATA_W-1:0]   transfer_buffer_i,
  input  wire                bus_collision_clear_i,
  input  wire                serial_port_irq_clear_i,
  input  wire                sda_i,
  input  wire                scl_i,
  output reg                 sda_o,
  output reg                 sda_oe_o,
  output reg                 scl_o,
  output reg                 scl_oe_o,
  output reg                 sck_o,
  output reg                 mosi_o,
  output reg                 start_seq_en_o,
  output reg                 rstart_seq_en_o,
  output reg                 stop_seq_en_o,
  output reg                 transfer_busy_o,
  output reg                 bus_collision_flag_o,
  output reg                 serial_port_irq_flag_o
);

  // ****************************************************
  // states
  // ****************************************************
  localparam [13:0] ST_IDLE     = 14'h0001;
  localparam [13:0] ST_S_CHK    = 14'h0002;
  localparam [13:0] ST_S_WAIT   = 14'h0004;
  localparam [13:0] ST_S_HOLD   = 14'h0008;
  localparam [13:0] ST_R_SDAREL = 14'h0010;
  localparam [13:0] ST_R_CNT    = 14'h0020;
  localparam [13:0] ST_R_SCLHI  = 14'h0040;
  localparam [13:0] ST_R_WAIT   = 14'h0080;
  localparam [13:0] ST_R_HOLD   = 14'h0100;
  localparam [13:0] ST_P_SDALO  = 14'h0200;
  localparam [13:0] ST_P_SCLHI  = 14'h0400;
  localparam [13:0] ST_P_CNT    = 14'h0800;
  localparam [13:0] ST_P_REL    = 14'h1000;
  localparam [13:0] ST_XFER     = 14'h2000;

  // ****************************************************
  // declarations
  // ****************************************************
  reg  [13:0]       state_r;
  reg  [13:0]       state_nxt;
  reg               sda_oe_nxt;
  reg               scl_oe_nxt;
  reg               sck_nxt;
  reg               mosi_nxt;
  reg               start_en_nxt;
  reg               rstart_en_nxt;
  reg               stop_en_nxt;
  reg               spi_r;
  reg               spi_nxt;
  reg               phase_r;
  reg               phase_nxt;
  reg  [3:0]        bit_r;
  reg  [3:0]        bit_nxt;
  reg  [DATA_W-1:0] shift_r;
  reg  [DATA_W-1:0] shift_nxt;
  reg               brg_load;
  reg               abort;
  reg               finish;
  wire [1:0]        lines_s;
  wire              sda_s;
  wire              scl_s;
  reg               scl_prev_r;
  wire              scl_rise;
  wire              scl_fall;
  wire              brg_timeout;
  wire              i2c_mode;
  wire              spi_mode;
  wire              brg_run;

  // ****************************************************
  // pin synchronisers and counter
  // ****************************************************
  line_sync #(
    .WIDTH   (2)
  ) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i ({sda_i, scl_i}),
    .sync_o  (lines_s)
  );

  assign sda_s = lines_s[1];
  assign scl_s = lines_s[0];

  // edges seen on synchronised copy only
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_prev_r <= `PIN_IDLE_HIGH;
    end else begin
      scl_prev_r <= scl_s;
    end
  end

  assign scl_rise = scl_s & ~scl_prev_r;
  assign scl_fall = ~scl_s & scl_prev_r;

  assign i2c_mode = (port_mode_select_i == `MODE_I2C_MASTER);
  assign spi_mode = (port_mode_select_i == `MODE_SPI_MASTER_BRG);

  // counter halts whenever nothing is in progress
  assign brg_run = (state_r != ST_IDLE);

  baud_rate_counter #(
    .W         (RELOAD_W)
  ) u_brg (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .load_i    (brg_load),
    .run_i     (brg_run),
    .reload_i  (rate_reload_value_i),
    .timeout_o (brg_timeout)
  );

  // ****************************************************
  // sequencer
  // ****************************************************
  always @* begin
    state_nxt     = state_r;
    sda_oe_nxt    = sda_oe_o;
    scl_oe_nxt    = scl_oe_o;
    sck_nxt       = sck_o;
    mosi_nxt      = mosi_o;
    start_en_nxt  = start_seq_en_o;
    rstart_en_nxt = rstart_seq_en_o;
    stop_en_nxt   = stop_seq_en_o;
    spi_nxt       = spi_r;
    phase_nxt     = phase_r;
    bit_nxt       = bit_r;
    shift_nxt     = shift_r;
    brg_load      = `FLAG_CLEAR;
    abort         = `FLAG_CLEAR;
    finish        = `FLAG_CLEAR;
    case (state_r)
      ST_IDLE: begin
        if (i2c_mode && start_req_i) begin
          start_en_nxt = ~`FLAG_CLEAR;
          state_nxt    = ST_S_CHK;
        end else if (i2c_mode && rstart_req_i) begin
          rstart_en_nxt = ~`FLAG_CLEAR;
          sda_oe_nxt    = `LINE_RELEASED;
          state_nxt     = ST_R_SDAREL;
        end else if (i2c_mode && stop_req_i) begin
          stop_en_nxt = ~`FLAG_CLEAR;
          sda_oe_nxt  = ~`LINE_RELEASED;
          state_nxt   = ST_P_SDALO;
        end else if ((i2c_mode || spi_mode) && transfer_buffer_wr_i) begin
          brg_load   = ~`FLAG_CLEAR;
          spi_nxt    = spi_mode;
          phase_nxt  = `FLAG_CLEAR;
          bit_nxt    = `BIT_RESET;
          shift_nxt  = {transfer_buffer_i[DATA_W-2:0], `SHIFT_FILL};
          if (spi_mode) begin
            mosi_nxt = transfer_buffer_i[`DATA_MSB];
          end else begin
            scl_oe_nxt = ~`LINE_RELEASED;
            sda_oe_nxt = ~transfer_buffer_i[`DATA_MSB];
          end
          state_nxt  = ST_XFER;
        end
      end
      ST_S_CHK: begin
        if (!sda_s || !scl_s) begin
          abort = ~`FLAG_CLEAR;
        end else begin
          brg_load  = ~`FLAG_CLEAR;
          state_nxt = ST_S_WAIT;
        end
      end
      ST_S_WAIT: begin
        if (!scl_s) begin
          abort = ~`FLAG_CLEAR;
        end else if (!sda_s || brg_timeout) begin
          // another master won sda first: follow it at once
          sda_oe_nxt = ~`LINE_RELEASED;
          brg_load   = ~`FLAG_CLEAR;
          state_nxt  = ST_S_HOLD;
        end
      end
      ST_S_HOLD: begin
        // scl low here is tolerated on purpose
        if (brg_timeout) begin
          scl_oe_nxt = ~`LINE_RELEASED;
          finish     = ~`FLAG_CLEAR;
        end
      end
      ST_R_SDAREL: begin
        if (sda_s) begin
          brg_load  = ~`FLAG_CLEAR;
          state_nxt = ST_R_CNT;
        end
      end
      ST_R_CNT: begin
        if (brg_timeout) begin
          scl_oe_nxt = `LINE_RELEASED;
          state_nxt  = ST_R_SCLHI;
        end
      end
      ST_R_SCLHI: begin
        // waits out clock stretching by others
        if (scl_rise) begin
          if (!sda_s) begin
            abort = ~`FLAG_CLEAR;
          end else begin
            brg_load  = ~`FLAG_CLEAR;
            state_nxt = ST_R_WAIT;
          end
        end
      end
      ST_R_WAIT: begin
        if (scl_fall && !sda_oe_o) begin
          abort = ~`FLAG_CLEAR;
        end else if (brg_timeout) begin
          // a foreign sda fall before here is not a collision
          sda_oe_nxt = ~`LINE_RELEASED;
          brg_load   = ~`FLAG_CLEAR;
          state_nxt  = ST_R_HOLD;
        end
      end
      ST_R_HOLD: begin
        if (brg_timeout) begin
          scl_oe_nxt = ~`LINE_RELEASED;
          finish     = ~`FLAG_CLEAR;
        end
      end
      ST_P_SDALO: begin
        if (!sda_s) begin
          scl_oe_nxt = `LINE_RELEASED;
          state_nxt  = ST_P_SCLHI;
        end
      end
      ST_P_SCLHI: begin
        if (scl_s) begin
          brg_load  = ~`FLAG_CLEAR;
          state_nxt = ST_P_CNT;
        end
      end
      ST_P_CNT: begin
        if (!scl_s) begin
          abort = ~`FLAG_CLEAR;
        end else if (brg_timeout) begin
          sda_oe_nxt = `LINE_RELEASED;
          brg_load   = ~`FLAG_CLEAR;
          state_nxt  = ST_P_REL;
        end
      end
      ST_P_REL: begin
        if (!scl_s && !sda_s) begin
          abort = ~`FLAG_CLEAR;
        end else if (brg_timeout) begin
          if (!sda_s) begin
            abort = ~`FLAG_CLEAR;
          end else begin
            finish = ~`FLAG_CLEAR;
          end
        end
      end
      ST_XFER: begin
        if (!phase_r) begin
          if (brg_timeout) begin
            phase_nxt = ~`FLAG_CLEAR;
            if (spi_r) begin
              sck_nxt = ~sck_o;
            end else begin
              scl_oe_nxt = `LINE_RELEASED;
              brg_load   = ~`FLAG_CLEAR;
            end
          end
        end else if (!spi_r && !scl_s) begin
          // i2c high phase counts only once scl reads high
          brg_load = ~`FLAG_CLEAR;
        end else if (brg_timeout) begin
          phase_nxt = `FLAG_CLEAR;
          if (spi_r) begin
            sck_nxt = ~sck_o;
          end else begin
            scl_oe_nxt = ~`LINE_RELEASED;
            brg_load   = ~`FLAG_CLEAR;
          end
          if (bit_r == (spi_r ? `SPI_LAST_BIT : `I2C_LAST_BIT)) begin
            finish = ~`FLAG_CLEAR;
          end else begin
            bit_nxt   = bit_r + `BIT_STEP;
            shift_nxt = {shift_r[DATA_W-2:0], `SHIFT_FILL};
            if (spi_r) begin
              mosi_nxt = shift_r[`DATA_MSB];
            end else begin
              sda_oe_nxt = ~shift_r[`DATA_MSB];
            end
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (finish) begin
      state_nxt     = ST_IDLE;
      start_en_nxt  = `FLAG_CLEAR;
      rstart_en_nxt = `FLAG_CLEAR;
      stop_en_nxt   = `FLAG_CLEAR;
    end
    if (abort || !port_enable_i) begin
      state_nxt     = ST_IDLE;
      sda_oe_nxt    = `LINE_RELEASED;
      scl_oe_nxt    = `LINE_RELEASED;
      start_en_nxt  = `FLAG_CLEAR;
      rstart_en_nxt = `FLAG_CLEAR;
      stop_en_nxt   = `FLAG_CLEAR;
    end
  end

  // ****************************************************
  // registers
  // ****************************************************
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r         <= ST_IDLE;
      sda_oe_o        <= `LINE_RELEASED;
      scl_oe_o        <= `LINE_RELEASED;
      sda_o           <= `PIN_LOW_LEVEL;
      scl_o           <= `PIN_LOW_LEVEL;
      sck_o           <= `SCK_RESET_LEVEL;
      mosi_o          <= `FLAG_CLEAR;
      start_seq_en_o  <= `FLAG_CLEAR;
      rstart_seq_en_o <= `FLAG_CLEAR;
      stop_seq_en_o   <= `FLAG_CLEAR;
      transfer_busy_o <= `FLAG_CLEAR;
      spi_r           <= `FLAG_CLEAR;
      phase_r         <= `FLAG_CLEAR;
      bit_r           <= `BIT_RESET;
      shift_r         <= {DATA_W{`FLAG_CLEAR}};
    end else begin
      state_r         <= state_nxt;
      sda_oe_o        <= sda_oe_nxt;
      scl_oe_o        <= scl_oe_nxt;
      sda_o           <= `PIN_LOW_LEVEL;
      scl_o           <= `PIN_LOW_LEVEL;
      sck_o           <= sck_nxt;
      mosi_o          <= mosi_nxt;
      start_seq_en_o  <= start_en_nxt;
      rstart_seq_en_o <= rstart_en_nxt;
      stop_seq_en_o   <= stop_en_nxt;
      transfer_busy_o <= (state_nxt == ST_XFER);
      spi_r           <= spi_nxt;
      phase_r         <= phase_nxt;
      bit_r           <= bit_nxt;
      shift_r         <= shift_nxt;
    end
  end

  // ****************************************************
  // flags
  // ****************************************************
  // a set in the clearing cycle wins, so no event is lost
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_collision_flag_o   <= `FLAG_CLEAR;
      serial_port_irq_flag_o <= `FLAG_CLEAR;
    end else begin
      bus_collision_flag_o   <= (abort & port_enable_i) |
        (bus_collision_flag_o & ~bus_collision_clear_i);
      serial_port_irq_flag_o <= (finish & ~abort & port_enable_i) |
        (serial_port_irq_flag_o & ~serial_port_irq_clear_i);
    end
  end

endmodule // i2c_master_bus_collision_brg

`default_nettype wire

// *** rtl/i2c_collision_regs.vh ***
// constants for the i2c master collision and baud rate block
`ifndef I2C_COLLISION_REGS_VH
`define I2C_COLLISION_REGS_VH

// port mode codes that use the baud rate counter
`define MODE_I2C_MASTER     4'h8
`define MODE_SPI_MASTER_BRG 4'hA

// reset values
`define LINE_RELEASED       1'b0
`define FLAG_CLEAR          1'b0
`define PIN_IDLE_HIGH       1'b1
`define PIN_LOW_LEVEL       1'b0
`define SCK_RESET_LEVEL     1'b0
`define COUNT_RESET         8'h00
`define BIT_RESET           4'h0

// transfer framing
`define I2C_LAST_BIT        4'h8
`define SPI_LAST_BIT        4'h7
`define BIT_STEP            4'h1
`define SHIFT_FILL          1'b1
`define DATA_MSB            7

// baud rate counter
`define BRG_TERMINAL        8'h00
`define BRG_STEP            8'h01

`endif

// *** rtl/line_sync.v ***
// two flip-flop synchroniser for bus pins
`timescale 1ns/1ps
`default_nettype none
`include "i2c_collision_regs.vh"

module line_sync #(
  parameter WIDTH = 2
) (
  input  wire             clock_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_r;

  // idle bus reads high, so reset to high avoids a false low
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= {WIDTH{`PIN_IDLE_HIGH}};
      sync_o <= {WIDTH{`PIN_IDLE_HIGH}};
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule // line_sync

`default_nettype wire

// *** rtl/baud_rate_counter.v ***
// baud rate down-counter with half-rate decrement enable
`timescale 1ns/1ps
`default_nettype none
`include "i2c_collision_regs.vh"

module baud_rate_counter #(
  parameter W = 8
) (
  input  wire         clock_i,
  input  wire         rst_n_i,
  input  wire         load_i,
  input  wire         run_i,
  input  wire [W-1:0] reload_i,
  output reg          timeout_o
);

  reg [W-1:0] count_r;
  reg         tick_r;

  // one rollover spans 2*(reload+1) clocks
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r   <= `COUNT_RESET;
      tick_r    <= `FLAG_CLEAR;
      timeout_o <= `FLAG_CLEAR;
    end else begin
      timeout_o <= `FLAG_CLEAR;
      if (load_i) begin
        count_r <= reload_i;
        tick_r  <= `FLAG_CLEAR;
      end else if (run_i) begin
        tick_r <= ~tick_r;
        if (tick_r) begin
          if (count_r == `BRG_TERMINAL) begin
            timeout_o <= ~`FLAG_CLEAR;
            count_r   <= reload_i;
          end else begin
            count_r <= count_r - `BRG_STEP;
          end
        end
      end
    end
  end

endmodule // baud_rate_counter

`default_nettype wire

// *** tb/i2c_bus_partner.sv ***
// far-side bus model: pull-ups, other masters' pulls, foreign clock
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_partner (
  input  wire logic dut_sda_oe_i,
  input  wire logic dut_scl_oe_i,
  input  wire logic hold_sda_i,
  input  wire logic hold_scl_i,
  input  wire logic clk_run_i,
  output wire logic sda_o,
  output wire logic scl_o
);
  logic fclk = 1'b1;
  // 64 ns foreign clock, odd phase, stands high when off
  initial begin
    #3;
    forever #32 fclk = clk_run_i ? ~fclk : 1'b1;
  end
  // open drain with pull-up: any party pulling wins
  assign sda_o = ~(dut_sda_oe_i | hold_sda_i);
  assign scl_o = ~(dut_scl_oe_i | hold_scl_i | ~fclk);
endmodule // i2c_bus_partner
`default_nettype wire

// *** tb/i2c_collision_asserts.sv ***
// port-level checks for the collision-aware i2c master
`timescale 1ns/1ps
`default_nettype none
module i2c_collision_asserts (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic transfer_buffer_wr_i,
  input wire logic bus_collision_clear_i,
  input wire logic sda_oe_o,
  input wire logic scl_oe_o,
  input wire logic sck_o,
  input wire logic start_seq_en_o,
  input wire logic rstart_seq_en_o,
  input wire logic stop_seq_en_o,
  input wire logic transfer_busy_o,
  input wire logic bus_collision_flag_o,
  input wire logic serial_port_irq_flag_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  flag_sticky_a: assert property (
    $past(bus_collision_flag_o) && !$past(bus_collision_clear_i)
    |-> bus_collision_flag_o) else $error("collision flag lost");
  abort_release_a: assert property (
    $rose(bus_collision_flag_o) |-> !sda_oe_o && !scl_oe_o &&
    !start_seq_en_o && !rstart_seq_en_o && !stop_seq_en_o)
    else $error("abort left lines or enables");
  collision_cause_a: assert property (
    $rose(bus_collision_flag_o) |-> $past(start_seq_en_o |
    rstart_seq_en_o | stop_seq_en_o | transfer_busy_o))
    else $error("collision outside operation");
  no_irq_abort_a: assert property (
    $rose(bus_collision_flag_o) |-> !$rose(serial_port_irq_flag_o))
    else $error("irq set on abort");
  seq_order_a: assert property (
    $rose(scl_oe_o) && $past(start_seq_en_o | rstart_seq_en_o)
    |-> sda_oe_o && $past(sda_oe_o, 6)) else $error("scl before sda");
  start_idle_a: assert property (
    $rose(start_seq_en_o) |-> !sda_oe_o && !scl_oe_o)
    else $error("start with lines held");
  stop_release_a: assert property (
    $fell(stop_seq_en_o) |-> !sda_oe_o && !scl_oe_o)
    else $error("stop left lines held");
  busy_cause_a: assert property (
    $rose(transfer_busy_o) |-> $past(transfer_buffer_wr_i))
    else $error("transfer without buffer write");
  sck_hold_a: assert property (
    !transfer_busy_o && !$past(transfer_busy_o) |-> $stable(sck_o))
    else $error("sck moved while idle");
endmodule // i2c_collision_asserts
bind i2c_master_bus_collision_brg i2c_collision_asserts chk_u (
  .clock_i(clock_i), .rst_n_i(rst_n_i),
  .transfer_buffer_wr_i(transfer_buffer_wr_i),
  .bus_collision_clear_i(bus_collision_clear_i),
  .sda_oe_o(sda_oe_o), .scl_oe_o(scl_oe_o), .sck_o(sck_o),
  .start_seq_en_o(start_seq_en_o), .rstart_seq_en_o(rstart_seq_en_o),
  .stop_seq_en_o(stop_seq_en_o), .transfer_busy_o(transfer_busy_o),
  .bus_collision_flag_o(bus_collision_flag_o),
  .serial_port_irq_flag_o(serial_port_irq_flag_o));
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the collision-aware i2c master
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clock_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       en      = 1'b0;
  logic [3:0] mode    = 4'h8;
  logic [7:0] rl      = 8'h05;
  logic [7:0] tbuf    = 8'h00;
  logic [7:0] got;
  logic       st = 1'b0, rs = 1'b0, sp = 1'b0, wr = 1'b0;
  logic       bc = 1'b0, ic = 1'b0, hs = 1'b0, hc = 1'b0, fc = 1'b0;
  wire        sda, scl, sda_o, sda_oe, scl_o, scl_oe, sck, mosi;
  wire        sen, rsen, pen, busy, bcf, irq;
  int         num_errors = 0;
  int         checks     = 0;
  int         t, t1, n;
  initial forever #4 clock_i = ~clock_i;
  i2c_master_bus_collision_brg dut_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .port_enable_i(en),
    .port_mode_select_i(mode), .rate_reload_value_i(rl),
    .start_req_i(st), .rstart_req_i(rs), .stop_req_i(sp),
    .transfer_buffer_wr_i(wr), .transfer_buffer_i(tbuf),
    .bus_collision_clear_i(bc), .serial_port_irq_clear_i(ic),
    .sda_i(sda), .scl_i(scl), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .scl_o(scl_o), .scl_oe_o(scl_oe), .sck_o(sck), .mosi_o(mosi),
    .start_seq_en_o(sen), .rstart_seq_en_o(rsen), .stop_seq_en_o(pen),
    .transfer_busy_o(busy), .bus_collision_flag_o(bcf),
    .serial_port_irq_flag_o(irq));
  i2c_bus_partner part_u (
    .dut_sda_oe_i(sda_oe), .dut_scl_oe_i(scl_oe), .hold_sda_i(hs),
    .hold_scl_i(hc), .clk_run_i(fc), .sda_o(sda), .scl_o(scl));
  // ********************
  // tasks
  // ********************
  task automatic final_report;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic int tbrg(input logic [7:0] r);
    return 2 * (r + 1);
  endfunction
  task automatic tick(input int k);
    repeat (k) @(negedge clock_i);
  endtask
  task automatic req(input int k);
    {st, rs, sp, wr, bc, ic} = 6'h20 >> k;
    tick(1);
    {st, rs, sp, wr, bc, ic} = 6'h00;
  endtask
  task automatic settle;
    n = 0;
    tick(2);
    while ((sen | rsen | pen | busy) !== 1'b0 && n < 4000) begin
      tick(1);
      n++;
    end
    tick(1);
    check(16'(n >= 4000), 16'h0000);
  endtask
  task automatic expect_end(input logic [3:0] exp);
    settle;
    check({10'h000, sda_o, scl_o, bcf, irq, sda_oe, scl_oe},
          {12'h000, exp});
  endtask
  task automatic clr;
    {bc, ic} = 2'b11;
    tick(1);
    {bc, ic} = 2'b00;
    tick(1);
    check({14'h0000, bcf, irq}, 16'h0000);
  endtask
  task automatic wait_low(input logic sel);
    n = 0;
    while ((sel ? sda_oe : scl_oe) !== 1'b0 && n < 400) begin
      tick(1);
      n++;
    end
    check(16'(n >= 400), 16'h0000);
  endtask
  // early: another master takes sda during the countdown
  task automatic start_run(input logic early);
    req(0);
    if (early) begin
      tick(3);
      hs = 1'b1;
    end
    t = 0;
    t1 = 0;
    while (scl_oe !== 1'b1 && t < 400) begin
      tick(1);
      t++;
      if (sda_oe === 1'b1 && t1 == 0) t1 = t;
    end
    hs = 1'b0;
    check(t - t1 >= tbrg(rl) && t - t1 <= tbrg(rl) + 2, 1'b1);
    if (early) check(t1 < tbrg(rl), 1'b1);
    else check(t1 >= tbrg(rl) && t1 <= tbrg(rl) + 5, 1'b1);
    expect_end(4'b0111);
    clr;
  endtask
  task automatic spi_run;
    logic p;
    int   k, f;
    mode = 4'hA;
    tbuf = 8'($urandom);
    got = 8'h00;
    k = 0;
    f = 0;
    t = 0;
    req(0);
    tick(1);
    check({15'h0000, sen}, 16'h0000);
    req(3);
    tick(1);
    p = sck;
    while (busy !== 1'b0 && t < 2000) begin
      tick(1);
      t++;
      if (sck !== p) begin
        if (k == 0) f = t;
        if (sck === 1'b1) got = {got[6:0], mosi};
        k++;
        t1 = t;
        p = sck;
      end
    end
    check(16'(k), 16'd16);
    check(16'(t1 - f), 16'(15 * tbrg(rl)));
    check({8'h00, got}, {8'h00, tbuf});
    tick(20);
    check({15'h0000, sck}, {15'h0000, p});
    mode = 4'h8;
    clr;
  endtask
  // i2c byte: bit seen on each scl release, ninth release is the ack
  task automatic i2c_run;
    logic p;
    int   k;
    tbuf = 8'($urandom);
    got  = 8'h00;
    k = 0;
    t = 0;
    req(3);
    p = scl_oe;
    while (busy !== 1'b0 && t < 2000) begin
      tick(1);
      t++;
      if (scl_oe === 1'b0 && p === 1'b1) begin
        if (k < 8) got = {got[6:0], ~sda_oe};
        else check({15'h0000, sda_oe}, 16'h0000);
        k++;
      end
      p = scl_oe;
    end
    check(16'(k), 16'h0009);
    check({8'h00, got}, {8'h00, tbuf});
    check({14'h0000, scl_oe, irq}, 16'h0003);
    clr;
  endtask
  // ********************
  // sequence
  // ********************
  initial begin
    void'($urandom(51874));
    tick(6);
    rst_n_i = 1'b1;
    en = 1'b1;
    tick(4);
    repeat (2) begin
      rl = 8'h05 + 8'($urandom % 6);
      for (int k = 0; k < 3; k++) begin
        hs = (k == 0);
        hc = (k == 1);
        tick(3);
        req(0);
        if (k == 2) begin
          tick(2);
          fc = 1'b1;
        end
        expect_end(4'b1000);
        {hs, hc, fc} = 3'b000;
        tick(8);
        clr;
      end
      start_run(1'b1);
      i2c_run;
      req(2);
      expect_end(4'b0100);
      clr;
      start_run(1'b0);
      req(1);
      // foreign sda fall while counting must not collide
      wait_low(1'b0);
      tick(4);
      hs = 1'b1;
      expect_end(4'b0111);
      hs = 1'b0;
      clr;
      req(2);
      expect_end(4'b0100);
      clr;
      // rstart: sda low at rise, early fall; stop: scl low, sda low
      for (int k = 0; k < 4; k++) begin
        start_run(1'b0);
        req(k < 2 ? 1 : 2);
        wait_low(k == 3);
        if (k == 1 || k == 2) tick(4);
        hs = (k == 0 || k == 3);
        hc = (k < 3);
        if (k == 0) begin
          tick(4);
          hc = 1'b0;
        end
        expect_end(4'b1000);
        {hs, hc} = 2'b00;
        tick(4);
        clr;
      end
      // enable drop mid-stop: idle, lines free, no flag
      start_run(1'b0);
      req(2);
      tick(3);
      en = 1'b0;
      tick(2);
      en = 1'b1;
      expect_end(4'b0000);
      spi_run;
    end
    final_report;
  end
  initial begin
    #200000;
    num_errors++;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
